// *** hw/sar_params.svh ***
/*
 * Frame layout and edge positions of the serial readout.
 * Assumes it is included by bare name by every file that needs them.
 */
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// ************************************************************
// Frame layout
// ************************************************************
`define SAR_RES_BITS 14
`define SAR_SUB_BITS 2
`define SAR_LEAD_ZEROS 8
`define SAR_FRAME_LEN 24
`define SAR_WORD_BITS 16

// ************************************************************
// Falling edge positions, counted from the select fall, and the first trial code
// ************************************************************
`define SAR_ACQ_END_EDGE 5'h06
`define SAR_LAST_BIT_EDGE 5'h14
`define SAR_SUB_HI_EDGE 5'h15
`define SAR_SUB_LO_EDGE 5'h16
`define SAR_FRAME_EDGE 5'h18
`define SAR_MSB_TRIAL 14'h2000

`endif

// *** hw/sar_pkg.sv ***
/*
 * Types shared by the serial readout design.
 * Assumes nothing beyond the parameter header.
 */
package sar_pkg;

    // Phase of a frame, seen from the link side.
    typedef enum logic [1:0] {
        PH_ACQ,
        PH_CONV,
        PH_TAIL
    } sar_phase_t;

endpackage : sar_pkg

// *** hw/sar_sync.sv ***
/*
 * Two flip-flop level synchroniser, one bit per lane.
 * Assumes the inputs are levels that hold for several destination clocks.
 */
`timescale 1ns/100ps
module sar_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule : sar_sync

// *** hw/sar_buf2.sv ***
/*
 * Two-entry buffer with registered outputs (main stage plus skid stage).
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module sar_buf2 #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] skid_r;
    logic [W-1:0] skid_nxt;
    logic skid_v_r;
    logic skid_v_nxt;
    logic out_v_nxt;
    logic [W-1:0] out_d_nxt;
    logic take;
    logic give;

    // The ready flag is a flop so the producer never sees a combinational
    // path from the consumer; the skid entry absorbs the one late word.
    always_comb begin
        take = in_valid && in_ready;
        give = out_valid && out_ready;
        skid_nxt = skid_r;
        skid_v_nxt = skid_v_r;
        out_v_nxt = out_valid;
        out_d_nxt = out_data;
        if (give || !out_valid) begin
            if (skid_v_r) begin
                out_v_nxt = 1'b1;
                out_d_nxt = skid_r;
                skid_v_nxt = take;
                skid_nxt = in_data;
            end else begin
                out_v_nxt = take;
                out_d_nxt = take ? in_data : out_data;
            end
        end else if (take) begin
            skid_v_nxt = 1'b1;
            skid_nxt = in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            skid_r <= '0;
            skid_v_r <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
            in_ready <= 1'b0;
        end else begin
            skid_r <= skid_nxt;
            skid_v_r <= skid_v_nxt;
            out_valid <= out_v_nxt;
            out_data <= out_d_nxt;
            in_ready <= !skid_v_nxt;
        end
    end
endmodule : sar_buf2

// *** hw/sar_readout.sv ***
/*
 * Conversion sequencing and serial readout of a 14-bit successive
 * approximation converter, plus a result port on the system clock.
 * Assumes: SCLK and CS_N come from an outside serial master; COMP is the
 * comparator output, settled on SCLK falling edges; the data pin driver
 * is built outside from DOUT and DOUT_OE.
 */
`timescale 1ns/100ps
`include "sar_params.svh"
module sar_readout
    import sar_pkg::*;
#(
    parameter int RES_BITS = `SAR_RES_BITS,
    parameter int SUB_BITS = `SAR_SUB_BITS
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic COMP,
    output logic DOUT,
    output logic DOUT_OE,
    output logic SAMPLE_TRACK,
    output logic [RES_BITS-1:0] TRIAL_CODE,
    output logic CONV_BUSY,
    output logic [RES_BITS+SUB_BITS-1:0] RESULT_DATA,
    output logic RESULT_VALID,
    input wire logic RESULT_READY,
    output logic RESULT_OVERRUN
);
    localparam int WW = RES_BITS + SUB_BITS;

    // ************************************************************
    // Frame bit selection
    // ************************************************************
    // Picks the level for frame position e (0 is the level right after
    // the select fall). Positions past the sub-bits read as zero.
    function automatic logic frame_bit(
        input logic [4:0] e,
        input logic [RES_BITS-1:0] code,
        input logic [SUB_BITS-1:0] sub
    );
        logic b;
        logic [4:0] idx;
        b = 1'b0;
        idx = 5'h00;
        if (e >= 5'(`SAR_LEAD_ZEROS) &&
            e < 5'(`SAR_LEAD_ZEROS + RES_BITS)) begin
            idx = 5'(`SAR_LEAD_ZEROS + RES_BITS - 1) - e;
            b = code[idx[3:0]];
        end else if (e >= 5'(`SAR_LEAD_ZEROS + RES_BITS) &&
                     e < 5'(`SAR_FRAME_LEN)) begin
            idx = 5'(`SAR_FRAME_LEN - 1) - e;
            b = sub[idx[0]];
        end
        return b;
    endfunction : frame_bit

    // ************************************************************
    // Successive approximation step
    // ************************************************************
    // Settles trial bit k from the comparator and puts the next lower
    // bit on trial. A comparator that has not settled by the edge gives
    // a wrong bit, and no later step can repair it.
    function automatic logic [RES_BITS-1:0] trial_step(
        input logic [RES_BITS-1:0] code,
        input logic [4:0] k,
        input logic cmp
    );
        logic [RES_BITS-1:0] t;
        t = code;
        t[k[3:0]] = cmp;
        if (k != 5'h00) begin
            t[k[3:0] - 4'h1] = 1'b1;
        end
        return t;
    endfunction : trial_step

    // ************************************************************
    // Link side: runs on SCLK falling edges, held reset by select high
    // ************************************************************
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [4:0] edge_no;
    sar_phase_t phase_r;
    sar_phase_t phase_nxt;
    logic track_r;
    logic track_nxt;
    logic [RES_BITS-1:0] trial_r;
    logic [RES_BITS-1:0] trial_nxt;
    logic [SUB_BITS-1:0] sub_r;
    logic [SUB_BITS-1:0] sub_nxt;
    logic dout_r;
    logic dout_nxt;
    logic [4:0] bit_idx;

    // The word handed to the system side and its event toggle are kept
    // out of the select reset, otherwise a prompt select rise after the
    // last edge would erase the result before the system side saw it.
    logic [WW-1:0] xfer_r;
    logic [WW-1:0] xfer_nxt;
    logic xfer_tgl_r;
    logic xfer_tgl_nxt;

    always_comb begin
        edge_no = cnt_r + 5'h01;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        track_nxt = track_r;
        trial_nxt = trial_r;
        sub_nxt = sub_r;
        bit_idx = 5'h00;
        xfer_nxt = xfer_r;
        xfer_tgl_nxt = xfer_tgl_r;
        case (phase_r)
            PH_ACQ: begin
                // The array follows the input until the sixth edge.
                cnt_nxt = edge_no;
                if (edge_no == `SAR_ACQ_END_EDGE) begin
                    track_nxt = 1'b0;
                    trial_nxt = `SAR_MSB_TRIAL;
                    phase_nxt = PH_CONV;
                end
            end
            PH_CONV: begin
                cnt_nxt = edge_no;
                if (edge_no <= `SAR_LAST_BIT_EDGE) begin
                    // One decision per edge, MSB first.
                    bit_idx = `SAR_LAST_BIT_EDGE - edge_no;
                    trial_nxt = trial_step(trial_r, bit_idx, COMP);
                end else if (edge_no == `SAR_SUB_HI_EDGE) begin
                    sub_nxt[1] = COMP;
                end else if (edge_no == `SAR_SUB_LO_EDGE) begin
                    sub_nxt[0] = COMP;
                end else if (edge_no == `SAR_FRAME_EDGE) begin
                    phase_nxt = PH_TAIL;
                    xfer_nxt = {trial_r, sub_r};
                    xfer_tgl_nxt = ~xfer_tgl_r;
                end
            end
            PH_TAIL: begin
                // The counter stops at the frame length so extra clocks
                // leave every converter register as it is.
                cnt_nxt = cnt_r;
            end
            default: begin
                // The spare encoding falls back to acquisition.
                phase_nxt = PH_ACQ;
            end
        endcase
        // Bits appear one edge after their decision: the MSB after the
        // 8th edge, the sub-bits last, zeros from then on.
        dout_nxt = frame_bit(cnt_nxt, trial_nxt, sub_nxt);
    end

    // Select high is the link-side reset: it abandons any conversion,
    // clears the registers and puts the array back on the input.
    always_ff @(negedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            cnt_r <= 5'h00;
            phase_r <= PH_ACQ;
            track_r <= 1'b1;
            trial_r <= '0;
            sub_r <= '0;
            dout_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            track_r <= track_nxt;
            trial_r <= trial_nxt;
            sub_r <= sub_nxt;
            dout_r <= dout_nxt;
        end
    end

    always_ff @(negedge SCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            xfer_r <= '0;
            xfer_tgl_r <= 1'b0;
        end else begin
            xfer_r <= xfer_nxt;
            xfer_tgl_r <= xfer_tgl_nxt;
        end
    end

    assign DOUT = dout_r;
    assign SAMPLE_TRACK = track_r;
    assign TRIAL_CODE = trial_r;

    // ************************************************************
    // System side: select status, output enable, result capture
    // ************************************************************
    logic cs_n_s;
    logic tgl_s;
    logic [1:0] sync_q;

    sar_sync #(
        .W(2),
        .RST_VAL(2'h1)
    ) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .d({xfer_tgl_r, CS_N}),
        .q(sync_q)
    );
    assign cs_n_s = sync_q[0];
    assign tgl_s = sync_q[1];

    logic oe_r;
    logic oe_nxt;
    logic busy_r;
    logic busy_nxt;
    logic tgl_seen_r;
    logic tgl_seen_nxt;
    logic [WW-1:0] pend_r;
    logic [WW-1:0] pend_nxt;
    logic pend_v_r;
    logic pend_v_nxt;
    logic ovr_r;
    logic ovr_nxt;
    logic buf_in_ready;
    logic new_word;

    // The data pin is released three system clocks after select rises and
    // driven three clocks after it falls; the enable rides the select only.
    always_comb begin
        oe_nxt = ~cs_n_s;
        busy_nxt = ~cs_n_s;
        new_word = tgl_s != tgl_seen_r;
        tgl_seen_nxt = tgl_s;
        pend_nxt = pend_r;
        pend_v_nxt = pend_v_r;
        ovr_nxt = ovr_r;
        if (pend_v_r && buf_in_ready) begin
            pend_v_nxt = 1'b0;
        end
        // A word that finds the holding stage still full replaces the
        // older one and leaves a sticky overrun mark.
        if (new_word) begin
            if (pend_v_r && !buf_in_ready) begin
                ovr_nxt = 1'b1;
            end
            pend_nxt = xfer_r;
            pend_v_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            oe_r <= 1'b0;
            busy_r <= 1'b0;
            tgl_seen_r <= 1'b0;
            pend_r <= '0;
            pend_v_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
            busy_r <= busy_nxt;
            tgl_seen_r <= tgl_seen_nxt;
            pend_r <= pend_nxt;
            pend_v_r <= pend_v_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    assign DOUT_OE = oe_r;
    assign CONV_BUSY = busy_r;
    assign RESULT_OVERRUN = ovr_r;

    // ************************************************************
    // Result buffer
    // ************************************************************
    sar_buf2 #(
        .W(WW)
    ) u_buf (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(pend_v_r),
        .in_ready(buf_in_ready),
        .in_data(pend_r),
        .out_valid(RESULT_VALID),
        .out_ready(RESULT_READY),
        .out_data(RESULT_DATA)
    );

endmodule : sar_readout

// *** test/sar_readout_asserts.sv ***
/* Checker for the serial readout: link framing and the result port.
   Assumes it is bound into sar_readout and sees only that module's ports. */
`timescale 1ns/100ps
module sar_readout_asserts #(
    parameter int RES_BITS = 14,
    parameter int SUB_BITS = 2
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic COMP,
    input wire logic DOUT,
    input wire logic DOUT_OE,
    input wire logic SAMPLE_TRACK,
    input wire logic [RES_BITS-1:0] TRIAL_CODE,
    input wire logic CONV_BUSY,
    input wire logic [RES_BITS+SUB_BITS-1:0] RESULT_DATA,
    input wire logic RESULT_VALID,
    input wire logic RESULT_READY,
    input wire logic RESULT_OVERRUN
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic hi_r;
    logic [4:0] pos;
    // Saturating, so that very long frames still count as past the end.
    always_comb cnt_nxt = (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01;
    always_ff @(negedge SCLK or posedge CS_N) begin
        if (CS_N) cnt_r <= 5'h00;
        else cnt_r <= cnt_nxt;
    end
    always_ff @(posedge SCLK) hi_r <= DOUT;
    assign pos = 5'h15 - cnt_r;

    a_idle_off: assert property (
        @(posedge CLK) disable iff (SYS_RST) CS_N [*5] |-> !DOUT_OE
        && !CONV_BUSY) else $error("output enabled in shutdown");
    a_active_on: assert property (
        @(posedge CLK) disable iff (SYS_RST) !CS_N [*5] |-> DOUT_OE
        && CONV_BUSY) else $error("output not enabled when selected");
    a_dout_quiet: assert property (
        @(posedge CLK) disable iff (SYS_RST) CS_N |-> !DOUT)
        else $error("data high in shutdown");
    a_abort_clear: assert property (
        @(posedge CLK) disable iff (SYS_RST) CS_N |-> TRIAL_CODE == '0)
        else $error("trial code kept in shutdown");
    a_array_tracks: assert property (
        @(posedge CLK) disable iff (SYS_RST) CS_N |-> SAMPLE_TRACK)
        else $error("array off the input in shutdown");
    a_only_fall: assert property (
        @(negedge SCLK) disable iff (CS_N) DOUT == hi_r)
        else $error("data changed while clock high");
    a_zero_pad: assert property (
        @(negedge SCLK) disable iff (CS_N)
        (cnt_r < 5'h08 || cnt_r > 5'h17) |-> !DOUT)
        else $error("padding bit not zero");
    a_sample_end: assert property (
        @(negedge SCLK) disable iff (CS_N)
        cnt_r < 5'h09 |-> SAMPLE_TRACK == (cnt_r < 5'h06))
        else $error("sampling did not end on sixth edge");
    a_msb_first: assert property (
        @(negedge SCLK) disable iff (CS_N) (cnt_r > 5'h07
        && cnt_r < 5'h16) |-> DOUT == TRIAL_CODE[pos])
        else $error("result bit out of order");
    a_tail_frozen: assert property (
        @(negedge SCLK) disable iff (CS_N) cnt_r > 5'h18 |->
        $stable(TRIAL_CODE) && !SAMPLE_TRACK)
        else $error("converter moved after the frame");
    a_valid_holds: assert property (
        @(posedge CLK) disable iff (SYS_RST) RESULT_VALID && !RESULT_READY
        |=> RESULT_VALID && $stable(RESULT_DATA))
        else $error("result dropped while stalled");
    a_overrun_sticky: assert property (
        @(posedge CLK) disable iff (SYS_RST) RESULT_OVERRUN |=> RESULT_OVERRUN)
        else $error("overrun flag cleared");
endmodule : sar_readout_asserts

bind sar_readout sar_readout_asserts #(
    .RES_BITS(RES_BITS), .SUB_BITS(SUB_BITS)
) sar_readout_asserts_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .SCLK(SCLK), .CS_N(CS_N), .COMP(COMP),
    .DOUT(DOUT), .DOUT_OE(DOUT_OE), .SAMPLE_TRACK(SAMPLE_TRACK),
    .TRIAL_CODE(TRIAL_CODE), .CONV_BUSY(CONV_BUSY),
    .RESULT_DATA(RESULT_DATA), .RESULT_VALID(RESULT_VALID),
    .RESULT_READY(RESULT_READY), .RESULT_OVERRUN(RESULT_OVERRUN)
);

// *** test/sar_host_model.sv ***
/* Serial master and ideal comparator on the far side of the readout.
   Assumes the data pin is built from the design's data and enable. */
`timescale 1ns/100ps
module sar_host_model (
    output logic sclk,
    output logic cs_n,
    output logic comp,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic sample_track,
    input wire logic [13:0] trial_code
);
    logic [13:0] analog_input = 14'h0000;
    logic [13:0] held_r = 14'h0000;
    logic last_r = 1'b0;
    logic pin;
    // Clock high and select low first, then a clean select rise resets
    // the link side before the first falling clock edge can reach it.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b0;
        #1 cs_n = 1'b1;
        #1 sclk = 1'b0;
    end
    // A released pin shows the inverse of its last level, never a free 0.
    always @(dout_oe or dout) if (dout_oe) last_r = dout;
    assign pin = dout_oe ? dout : ~last_r;
    always @(analog_input or sample_track)
        if (sample_track) held_r = analog_input;
    assign comp = (held_r >= trial_code);
    // The input moves after the eighth edge; a late hold would see it.
    task automatic frame(input logic [13:0] code, input int n,
                         output logic [31:0] bits);
        analog_input = code;
        cs_n = 1'b0;
        #100;
        bits = 32'h0;
        for (int i = 1; i <= n; i++) begin
            sclk = 1'b1;
            bits = {bits[30:0], pin};
            // Far faster than a real host; only the edge order matters
            // to the logic, and short frames keep the run brief.
            #7.5 sclk = 1'b0;
            if (i == 8) analog_input = ~code;
            #7.5;
        end
        cs_n = 1'b1;
        #60;
    endtask : frame
endmodule : sar_host_model

// *** test/tb.sv ***
/* Testbench: frames with corner and random codes, an abort, a stall.
   Assumes the design, the bound checker and the host model. */
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ready = 1'b0;
    logic rdy_on = 1'b1;
    logic rdy_rand = 1'b1;
    logic sclk, cs_n, comp, dout, dout_oe, strack, busy, valid, ovr;
    logic [13:0] trial;
    logic [15:0] rdata;
    logic [15:0] words[$];
    logic [31:0] bits;
    logic [13:0] sc[4];
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    sar_readout sar_readout_i (
        .CLK(clk), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n),
        .COMP(comp), .DOUT(dout), .DOUT_OE(dout_oe),
        .SAMPLE_TRACK(strack), .TRIAL_CODE(trial), .CONV_BUSY(busy),
        .RESULT_DATA(rdata), .RESULT_VALID(valid),
        .RESULT_READY(ready), .RESULT_OVERRUN(ovr)
    );
    sar_host_model sar_host_model_i (
        .sclk(sclk), .cs_n(cs_n), .comp(comp), .dout(dout),
        .dout_oe(dout_oe), .sample_track(strack), .trial_code(trial)
    );

    task automatic final_report();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [21:0] exp_top(input logic [13:0] c);
        return {8'h00, c};
    endfunction : exp_top

    task automatic run_frame(input logic [13:0] code, input int n);
        logic [31:0] fr;
        logic [15:0] w;
        sar_host_model_i.frame(code, n, bits);
        fr = bits >> (n - 24);
        check(fr[23:2], exp_top(code));
        // An ideal comparator settles exactly, so both extra decisions
        // come out as ones.
        check(fr[1:0], 2'h3);
        check(bits & ((32'h1 << (n - 24)) - 32'h1), 0);
        for (int i = 0; i < 100 && words.size() == 0; i++) @(posedge clk);
        check(words.size(), 1);
        w = words.pop_front();
        check(w, {code, fr[1:0]});
    endtask : run_frame

    always @(posedge clk) begin
        cycles <= cycles + 1;
        ready <= rdy_on & (rdy_rand ? 1'($urandom_range(1)) : 1'b1);
        if (cycles == 6000) begin
            err_total++;
            final_report();
        end
    end
    // Sampled mid-cycle, where valid and ready are both settled.
    always @(negedge clk) if (valid === 1'b1 && ready === 1'b1)
        words.push_back(rdata);

    initial begin
        void'($urandom(32'h5DB4));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        run_frame(14'h0000, 24);
        run_frame(14'h3FFF, 24);
        for (int i = 0; i < 6; i++) run_frame(14'($urandom), 24 + i);
        $display("frames test done");
        sar_host_model_i.frame(14'h1555, 12, bits);
        repeat (20) @(posedge clk);
        check(words.size(), 0);
        check(dout_oe, 0);
        run_frame(14'h2AAA, 24);
        $display("abort test done");
        @(posedge clk);
        rdy_on <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            sc[i] = 14'($urandom);
            check(ovr, 0);
            sar_host_model_i.frame(sc[i], 24, bits);
        end
        repeat (10) @(posedge clk);
        check(ovr, 1);
        rdy_on <= 1'b1;
        rdy_rand <= 1'b0;
        repeat (20) @(posedge clk);
        check(words.size(), 3);
        check(words[0][15:2], sc[0]);
        check(words[1][15:2], sc[1]);
        check(words[2][15:2], sc[3]);
        $display("stall test done");
        final_report();
    end
endmodule : tb
